// ==== design/mit_consts.svh ====
// Constants for the transfer instruction length and timing model
`ifndef MIT_CONSTS_SVH
`define MIT_CONSTS_SVH
`define MIT_REGION_RESET 8'h01
`define MIT_PORT_ADD     5'h01
`define MIT_PERIPH_ADD   5'h02
`define MIT_EXT1_ADD     5'h01
`define MIT_EXT2_ADD     5'h02
`define MIT_ZERO_FILL    16'h0000
`define MIT_ONE_FILL     16'hFFFF
`define MIT_RES_DIRECT_BIN_LEN      3'h2
`define MIT_RES_DIRECT_BIN_ST       5'h01
`define MIT_RES_DIRECT_SRC_LEN      3'h2
`define MIT_RES_DIRECT_SRC_ST       5'h01
`define MIT_RES_INDIRECT_BIN_LEN    3'h1
`define MIT_RES_INDIRECT_BIN_ST     5'h02
`define MIT_RES_INDIRECT_SRC_LEN    3'h2
`define MIT_RES_INDIRECT_SRC_ST     5'h03
`define MIT_RES_IMM_BIN_LEN         3'h2
`define MIT_RES_IMM_BIN_ST          5'h01
`define MIT_RES_IMM_SRC_LEN         3'h2
`define MIT_RES_IMM_SRC_ST          5'h01
`define MIT_DIRECT_RES_BIN_LEN      3'h2
`define MIT_DIRECT_RES_BIN_ST       5'h02
`define MIT_DIRECT_RES_SRC_LEN      3'h2
`define MIT_DIRECT_RES_SRC_ST       5'h02
`define MIT_DIRECT_DIRECT_BIN_LEN   3'h3
`define MIT_DIRECT_DIRECT_BIN_ST    5'h03
`define MIT_DIRECT_DIRECT_SRC_LEN   3'h3
`define MIT_DIRECT_DIRECT_SRC_ST    5'h03
`define MIT_INDIRECT_IMM_BIN_LEN    3'h2
`define MIT_INDIRECT_IMM_BIN_ST     5'h03
`define MIT_INDIRECT_IMM_SRC_LEN    3'h3
`define MIT_INDIRECT_IMM_SRC_ST     5'h04
`define MIT_POINTER_IMM_BIN_LEN     3'h3
`define MIT_POINTER_IMM_BIN_ST      5'h02
`define MIT_POINTER_IMM_SRC_LEN     3'h3
`define MIT_POINTER_IMM_SRC_ST      5'h02
`define MIT_REG_MOVE_BIN_LEN        3'h3
`define MIT_REG_MOVE_BIN_ST         5'h02
`define MIT_REG_MOVE_SRC_LEN        3'h2
`define MIT_REG_MOVE_SRC_ST         5'h01
`define MIT_DWORD_MOVE_BIN_LEN      3'h3
`define MIT_DWORD_MOVE_BIN_ST       5'h03
`define MIT_DWORD_MOVE_SRC_LEN      3'h2
`define MIT_DWORD_MOVE_SRC_ST       5'h02
`define MIT_WORD_IMM16_BIN_LEN      3'h5
`define MIT_WORD_IMM16_BIN_ST       5'h03
`define MIT_WORD_IMM16_SRC_LEN      3'h4
`define MIT_WORD_IMM16_SRC_ST       5'h02
`define MIT_DWORD_IMM_BIN_LEN       3'h5
`define MIT_DWORD_IMM_BIN_ST        5'h05
`define MIT_DWORD_IMM_SRC_LEN       3'h4
`define MIT_DWORD_IMM_SRC_ST        5'h04
`define MIT_DWORD_DIRECT_BIN_LEN    3'h4
`define MIT_DWORD_DIRECT_BIN_ST     5'h06
`define MIT_DWORD_DIRECT_SRC_LEN    3'h3
`define MIT_DWORD_DIRECT_SRC_ST     5'h05
`define MIT_WORD_WIDE_BIN_LEN       3'h5
`define MIT_WORD_WIDE_BIN_ST        5'h04
`define MIT_WORD_WIDE_SRC_LEN       3'h4
`define MIT_WORD_WIDE_SRC_ST        5'h03
`define MIT_BYTE_FAR_PTR_BIN_LEN    3'h4
`define MIT_BYTE_FAR_PTR_BIN_ST     5'h04
`define MIT_BYTE_FAR_PTR_SRC_LEN    3'h3
`define MIT_BYTE_FAR_PTR_SRC_ST     5'h03
`endif

// ==== design/mit_pkg.sv ====
// Types for the transfer instruction length and timing model
package mit_pkg;
    typedef enum logic [3:0] {
        MIT_RES_DIRECT, MIT_RES_INDIRECT, MIT_RES_IMM, MIT_DIRECT_RES, MIT_DIRECT_DIRECT,
        MIT_INDIRECT_IMM, MIT_POINTER_IMM, MIT_BYTE_BYTE, MIT_WORD_WORD, MIT_DWORD_DWORD,
        MIT_WORD_IMM16, MIT_DWORD_IMM_ZERO, MIT_DWORD_IMM_ONE, MIT_DWORD_DIRECT, MIT_WORD_WIDE, MIT_BYTE_FAR_PTR
    } mit_form_t;
    typedef enum logic [1:0] {MIT_LOC_PLAIN, MIT_LOC_PORT, MIT_LOC_PERIPH, MIT_LOC_EXT} mit_loc_t;
    typedef struct packed {
        logic      valid;
        mit_form_t form;
        mit_loc_t  loc_a;
        mit_loc_t  loc_b;
        logic [3:0] wait_n;
        logic [15:0] imm;
    } mit_req_t;
    typedef struct packed {
        logic        valid;
        logic [2:0]  bytes;
        logic [4:0]  states;
        logic [31:0] ext_value;
    } mit_rsp_t;
    typedef struct packed {
        logic     src_mode;
        logic     mode_ok;
        logic [7:0] region;
        mit_rsp_t rsp;
    } mit_state_t;
endpackage

// ==== design/mit_timing.sv ====
// Length and state-count model for transfer instructions
`timescale 1ns/100ps
`default_nettype none
`include "mit_consts.svh"
module mit_timing (
    input  wire logic            sys_clk_i,
    input  wire logic            reset_i,
    input  wire logic            src_mode_strap_i,
    input  wire mit_pkg::mit_req_t req_i,
    input  wire logic            region_we_i,
    input  wire logic [7:0]      region_i,
    output logic                 rsp_valid_o,
    output logic [2:0]           rsp_bytes_o,
    output logic [4:0]           rsp_states_o,
    output logic [31:0]          rsp_ext_value_o,
    output logic [7:0]           region_o
);
    mit_pkg::mit_state_t st_r;
    mit_pkg::mit_state_t st_nxt;

    // Penalty for one operand; kind 1 = port/peripheral, 2 = ext N+1, 3 = ext N+2
    function automatic logic [4:0] pen(input mit_pkg::mit_loc_t loc, input logic [1:0] kind,
                                        input logic [3:0] n);
        pen = 5'h00;
        if (kind == 2'h1 && loc == mit_pkg::MIT_LOC_PORT)
            pen = `MIT_PORT_ADD;
        else if (kind == 2'h1 && loc == mit_pkg::MIT_LOC_PERIPH)
            pen = `MIT_PERIPH_ADD;
        else if (kind == 2'h2 && loc == mit_pkg::MIT_LOC_EXT)
            pen = {1'b0, n} + `MIT_EXT1_ADD;
        else if (kind == 2'h3 && loc == mit_pkg::MIT_LOC_EXT)
            pen = {1'b0, n} + `MIT_EXT2_ADD;
    endfunction

    // Column select; strap read once so the column cannot move mid-run
    function automatic logic [7:0] pick(input logic       mode,
                                        input logic [2:0] bin_len,
                                        input logic [4:0] bin_st,
                                        input logic [2:0] src_len,
                                        input logic [4:0] src_st);
        pick = mode ? {src_len, src_st} : {bin_len, bin_st};
    endfunction

    always_comb
    begin
        logic [2:0] b;
        logic [4:0] s;
        logic [1:0] k;
        b = 3'h0;
        s = 5'h00;
        k = 2'h0;
        st_nxt = st_r;
        st_nxt.mode_ok = 1'b1;
        if (!st_r.mode_ok)
            st_nxt.src_mode = src_mode_strap_i;
        if (region_we_i)
            st_nxt.region = region_i;
        st_nxt.rsp.ext_value = 32'h0000_0000;
        unique case (req_i.form)
            mit_pkg::MIT_RES_DIRECT:
            begin
                {b, s} = pick(st_r.src_mode, `MIT_RES_DIRECT_BIN_LEN, `MIT_RES_DIRECT_BIN_ST,
                              `MIT_RES_DIRECT_SRC_LEN, `MIT_RES_DIRECT_SRC_ST);
                k = 2'h1;
            end
            mit_pkg::MIT_RES_INDIRECT:
            begin
                {b, s} = pick(st_r.src_mode, `MIT_RES_INDIRECT_BIN_LEN, `MIT_RES_INDIRECT_BIN_ST,
                              `MIT_RES_INDIRECT_SRC_LEN, `MIT_RES_INDIRECT_SRC_ST);
            end
            mit_pkg::MIT_RES_IMM:
            begin
                {b, s} = pick(st_r.src_mode, `MIT_RES_IMM_BIN_LEN, `MIT_RES_IMM_BIN_ST,
                              `MIT_RES_IMM_SRC_LEN, `MIT_RES_IMM_SRC_ST);
            end
            mit_pkg::MIT_DIRECT_RES:
            begin
                {b, s} = pick(st_r.src_mode, `MIT_DIRECT_RES_BIN_LEN, `MIT_DIRECT_RES_BIN_ST,
                              `MIT_DIRECT_RES_SRC_LEN, `MIT_DIRECT_RES_SRC_ST);
                k = 2'h1;
            end
            mit_pkg::MIT_DIRECT_DIRECT:
            begin
                {b, s} = pick(st_r.src_mode, `MIT_DIRECT_DIRECT_BIN_LEN, `MIT_DIRECT_DIRECT_BIN_ST,
                              `MIT_DIRECT_DIRECT_SRC_LEN, `MIT_DIRECT_DIRECT_SRC_ST);
                k = 2'h1;
            end
            mit_pkg::MIT_INDIRECT_IMM:
            begin
                {b, s} = pick(st_r.src_mode, `MIT_INDIRECT_IMM_BIN_LEN, `MIT_INDIRECT_IMM_BIN_ST,
                              `MIT_INDIRECT_IMM_SRC_LEN, `MIT_INDIRECT_IMM_SRC_ST);
            end
            mit_pkg::MIT_POINTER_IMM:
            begin
                {b, s} = pick(st_r.src_mode, `MIT_POINTER_IMM_BIN_LEN, `MIT_POINTER_IMM_BIN_ST,
                              `MIT_POINTER_IMM_SRC_LEN, `MIT_POINTER_IMM_SRC_ST);
            end
            mit_pkg::MIT_BYTE_BYTE, mit_pkg::MIT_WORD_WORD:
            begin
                {b, s} = pick(st_r.src_mode, `MIT_REG_MOVE_BIN_LEN, `MIT_REG_MOVE_BIN_ST,
                              `MIT_REG_MOVE_SRC_LEN, `MIT_REG_MOVE_SRC_ST);
            end
            mit_pkg::MIT_DWORD_DWORD:
            begin
                {b, s} = pick(st_r.src_mode, `MIT_DWORD_MOVE_BIN_LEN, `MIT_DWORD_MOVE_BIN_ST,
                              `MIT_DWORD_MOVE_SRC_LEN, `MIT_DWORD_MOVE_SRC_ST);
            end
            mit_pkg::MIT_WORD_IMM16:
            begin
                {b, s} = pick(st_r.src_mode, `MIT_WORD_IMM16_BIN_LEN, `MIT_WORD_IMM16_BIN_ST,
                              `MIT_WORD_IMM16_SRC_LEN, `MIT_WORD_IMM16_SRC_ST);
            end
            mit_pkg::MIT_DWORD_IMM_ZERO:
            begin
                {b, s} = pick(st_r.src_mode, `MIT_DWORD_IMM_BIN_LEN, `MIT_DWORD_IMM_BIN_ST,
                              `MIT_DWORD_IMM_SRC_LEN, `MIT_DWORD_IMM_SRC_ST);
                st_nxt.rsp.ext_value = {`MIT_ZERO_FILL, req_i.imm};
            end
            mit_pkg::MIT_DWORD_IMM_ONE:
            begin
                {b, s} = pick(st_r.src_mode, `MIT_DWORD_IMM_BIN_LEN, `MIT_DWORD_IMM_BIN_ST,
                              `MIT_DWORD_IMM_SRC_LEN, `MIT_DWORD_IMM_SRC_ST);
                st_nxt.rsp.ext_value = {`MIT_ONE_FILL, req_i.imm};
            end
            mit_pkg::MIT_DWORD_DIRECT:
            begin
                {b, s} = pick(st_r.src_mode, `MIT_DWORD_DIRECT_BIN_LEN, `MIT_DWORD_DIRECT_BIN_ST,
                              `MIT_DWORD_DIRECT_SRC_LEN, `MIT_DWORD_DIRECT_SRC_ST);
            end
            // word from wide direct; carries N+2
            mit_pkg::MIT_WORD_WIDE:
            begin
                {b, s} = pick(st_r.src_mode, `MIT_WORD_WIDE_BIN_LEN, `MIT_WORD_WIDE_BIN_ST,
                              `MIT_WORD_WIDE_SRC_LEN, `MIT_WORD_WIDE_SRC_ST);
                k = 2'h3;
            end
            mit_pkg::MIT_BYTE_FAR_PTR:
            begin
                {b, s} = pick(st_r.src_mode, `MIT_BYTE_FAR_PTR_BIN_LEN, `MIT_BYTE_FAR_PTR_BIN_ST,
                              `MIT_BYTE_FAR_PTR_SRC_LEN, `MIT_BYTE_FAR_PTR_SRC_ST);
                k = 2'h3;
            end
        endcase
        s = s + pen(req_i.loc_a, k, req_i.wait_n);
        if (req_i.form == mit_pkg::MIT_DIRECT_DIRECT)
            s = s + pen(req_i.loc_b, k, req_i.wait_n);
        st_nxt.rsp.valid = req_i.valid & st_r.mode_ok;
        st_nxt.rsp.bytes = b;
        st_nxt.rsp.states = s;
        if (reset_i)
        begin
            st_nxt.src_mode = 1'b0;
            st_nxt.mode_ok = 1'b0;
            st_nxt.region = `MIT_REGION_RESET;
            st_nxt.rsp = '0;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        st_r <= st_nxt;
    end

    assign rsp_valid_o = st_r.rsp.valid;
    assign rsp_bytes_o = st_r.rsp.bytes;
    assign rsp_states_o = st_r.rsp.states;
    assign rsp_ext_value_o = st_r.rsp.ext_value;
    assign region_o = st_r.region;

    // Reset high at one edge, low at the next
    sequence s_release;
        reset_i ##1 !reset_i;
    endsequence

    property p_imm_state;
        @(posedge sys_clk_i) disable iff (reset_i)
        req_i.valid && st_r.mode_ok && req_i.form == mit_pkg::MIT_RES_IMM
        |=> rsp_states_o == 5'h01 && rsp_bytes_o == 3'h2;
    endproperty
    a_imm_state: assert property (p_imm_state) else $error("Immediate cost wrong");

    property p_pointer_load;
        @(posedge sys_clk_i) disable iff (reset_i)
        req_i.valid && st_r.mode_ok && req_i.form == mit_pkg::MIT_POINTER_IMM
        |=> rsp_states_o == 5'h02 && rsp_bytes_o == 3'h3;
    endproperty
    a_pointer_load: assert property (p_pointer_load) else $error("Pointer load cost wrong");

    property p_zero_ext;
        @(posedge sys_clk_i) disable iff (reset_i)
        req_i.valid && st_r.mode_ok && req_i.form == mit_pkg::MIT_DWORD_IMM_ZERO
        |=> rsp_ext_value_o[31:16] == 16'h0000;
    endproperty
    a_zero_ext: assert property (p_zero_ext) else $error("Zero extension wrong");

    property p_one_ext;
        @(posedge sys_clk_i) disable iff (reset_i)
        req_i.valid && st_r.mode_ok && req_i.form == mit_pkg::MIT_DWORD_IMM_ONE
        |=> rsp_ext_value_o[31:16] == 16'hFFFF;
    endproperty
    a_one_ext: assert property (p_one_ext) else $error("One extension wrong");

    property p_ind_load;
        @(posedge sys_clk_i) disable iff (reset_i)
        req_i.valid && st_r.mode_ok && req_i.form == mit_pkg::MIT_RES_INDIRECT
        |=> rsp_states_o == (st_r.src_mode ? 5'h03 : 5'h02);
    endproperty
    a_ind_load: assert property (p_ind_load) else $error("Indirect load cost wrong");

    property p_port;
        @(posedge sys_clk_i) disable iff (reset_i)
        req_i.valid && st_r.mode_ok && req_i.form == mit_pkg::MIT_RES_DIRECT && req_i.loc_a == mit_pkg::MIT_LOC_PORT
        |=> rsp_states_o == 5'h02;
    endproperty
    a_port: assert property (p_port) else $error("Port penalty wrong");

    property p_periph;
        @(posedge sys_clk_i) disable iff (reset_i)
        req_i.valid && st_r.mode_ok && req_i.form == mit_pkg::MIT_DIRECT_RES && req_i.loc_a == mit_pkg::MIT_LOC_PERIPH
        |=> rsp_states_o == 5'h04;
    endproperty
    a_periph: assert property (p_periph) else $error("Peripheral penalty wrong");

    property p_mode_fixed;
        @(posedge sys_clk_i) disable iff (reset_i)
        st_r.mode_ok |=> $stable(st_r.src_mode);
    endproperty
    a_mode_fixed: assert property (p_mode_fixed) else $error("Mode changed after reset");

    property p_res_direct;
        @(posedge sys_clk_i) disable iff (reset_i)
        req_i.valid && st_r.mode_ok && req_i.form == mit_pkg::MIT_RES_DIRECT && req_i.loc_a == mit_pkg::MIT_LOC_PLAIN
        |=> rsp_bytes_o == 3'h2 && rsp_states_o == 5'h01;
    endproperty
    a_res_direct: assert property (p_res_direct) else $error("Direct load cost wrong");

    property p_res_store;
        @(posedge sys_clk_i) disable iff (reset_i)
        req_i.valid && st_r.mode_ok && req_i.form == mit_pkg::MIT_DIRECT_RES && req_i.loc_a == mit_pkg::MIT_LOC_PLAIN
        |=> rsp_bytes_o == 3'h2 && rsp_states_o == 5'h02;
    endproperty
    a_res_store: assert property (p_res_store) else $error("Result store cost wrong");

    property p_dir_dir;
        @(posedge sys_clk_i) disable iff (reset_i)
        req_i.valid && st_r.mode_ok && req_i.form == mit_pkg::MIT_DIRECT_DIRECT
        && req_i.loc_a == mit_pkg::MIT_LOC_PORT && req_i.loc_b == mit_pkg::MIT_LOC_PERIPH
        |=> rsp_bytes_o == 3'h3 && rsp_states_o == 5'h06;
    endproperty
    a_dir_dir: assert property (p_dir_dir) else $error("Two operand penalty wrong");

    property p_ind_imm;
        @(posedge sys_clk_i) disable iff (reset_i)
        req_i.valid && st_r.mode_ok && req_i.form == mit_pkg::MIT_INDIRECT_IMM
        |=> rsp_bytes_o == (st_r.src_mode ? 3'h3 : 3'h2) && rsp_states_o == (st_r.src_mode ? 5'h04 : 5'h03);
    endproperty
    a_ind_imm: assert property (p_ind_imm) else $error("Indirect immediate cost wrong");

    property p_reg_move;
        @(posedge sys_clk_i) disable iff (reset_i)
        req_i.valid && st_r.mode_ok && (req_i.form == mit_pkg::MIT_BYTE_BYTE || req_i.form == mit_pkg::MIT_WORD_WORD)
        |=> rsp_bytes_o == (st_r.src_mode ? 3'h2 : 3'h3) && rsp_states_o == (st_r.src_mode ? 5'h01 : 5'h02);
    endproperty
    a_reg_move: assert property (p_reg_move) else $error("Register move cost wrong");

    property p_dword_move;
        @(posedge sys_clk_i) disable iff (reset_i)
        req_i.valid && st_r.mode_ok && req_i.form == mit_pkg::MIT_DWORD_DWORD
        |=> rsp_bytes_o == (st_r.src_mode ? 3'h2 : 3'h3) && rsp_states_o == (st_r.src_mode ? 5'h02 : 5'h03);
    endproperty
    a_dword_move: assert property (p_dword_move) else $error("Dword move cost wrong");

    property p_word_imm;
        @(posedge sys_clk_i) disable iff (reset_i)
        req_i.valid && st_r.mode_ok && req_i.form == mit_pkg::MIT_WORD_IMM16
        |=> rsp_bytes_o == (st_r.src_mode ? 3'h4 : 3'h5) && rsp_states_o == (st_r.src_mode ? 5'h02 : 5'h03);
    endproperty
    a_word_imm: assert property (p_word_imm) else $error("Word immediate cost wrong");

    property p_dword_direct;
        @(posedge sys_clk_i) disable iff (reset_i)
        req_i.valid && st_r.mode_ok && req_i.form == mit_pkg::MIT_DWORD_DIRECT
        |=> rsp_bytes_o == (st_r.src_mode ? 3'h3 : 3'h4) && rsp_states_o == (st_r.src_mode ? 5'h05 : 5'h06);
    endproperty
    a_dword_direct: assert property (p_dword_direct) else $error("Dword direct cost wrong");

    property p_word_wide;
        @(posedge sys_clk_i) disable iff (reset_i)
        req_i.valid && st_r.mode_ok && req_i.form == mit_pkg::MIT_WORD_WIDE && req_i.loc_a != mit_pkg::MIT_LOC_EXT
        |=> rsp_bytes_o == (st_r.src_mode ? 3'h4 : 3'h5) && rsp_states_o == (st_r.src_mode ? 5'h03 : 5'h04);
    endproperty
    a_word_wide: assert property (p_word_wide) else $error("Wide direct cost wrong");

    property p_far_ptr;
        @(posedge sys_clk_i) disable iff (reset_i)
        req_i.valid && st_r.mode_ok && req_i.form == mit_pkg::MIT_BYTE_FAR_PTR && req_i.loc_a != mit_pkg::MIT_LOC_EXT
        |=> rsp_bytes_o == (st_r.src_mode ? 3'h3 : 3'h4) && rsp_states_o == (st_r.src_mode ? 5'h03 : 5'h04);
    endproperty
    a_far_ptr: assert property (p_far_ptr) else $error("Far pointer cost wrong");

    property p_ext_wait;
        @(posedge sys_clk_i) disable iff (reset_i)
        req_i.valid && st_r.mode_ok && req_i.form == mit_pkg::MIT_WORD_WIDE && req_i.loc_a == mit_pkg::MIT_LOC_EXT
        |=> rsp_states_o == (st_r.src_mode ? 5'h03 : 5'h04) + {1'b0, $past(req_i.wait_n)} + 5'h02;
    endproperty
    a_ext_wait: assert property (p_ext_wait) else $error("External wait penalty wrong");

    property p_region_reset;
        @(posedge sys_clk_i)
        reset_i
        |=> region_o == 8'h01 && !rsp_valid_o;
    endproperty
    a_region_reset: assert property (p_region_reset) else $error("Region reset value wrong");

    property p_region_write;
        @(posedge sys_clk_i) disable iff (reset_i)
        region_we_i
        |=> region_o == $past(region_i);
    endproperty
    a_region_write: assert property (p_region_write) else $error("Region write lost");

    property p_valid_follow;
        @(posedge sys_clk_i) disable iff (reset_i)
        st_r.mode_ok
        |=> rsp_valid_o == $past(req_i.valid);
    endproperty
    a_valid_follow: assert property (p_valid_follow) else $error("Answer valid wrong");

    property p_first_drop;
        @(posedge sys_clk_i)
        s_release
        |=> !rsp_valid_o;
    endproperty
    a_first_drop: assert property (p_first_drop) else $error("Request taken before mode latched");

    property p_mode_latch;
        @(posedge sys_clk_i)
        s_release
        |=> st_r.mode_ok && st_r.src_mode == $past(src_mode_strap_i);
    endproperty
    a_mode_latch: assert property (p_mode_latch) else $error("Mode strap not latched");
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the transfer instruction timing model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic              sys_clk_i = 1'b0;
    logic              reset_i = 1'b1;
    logic              src_mode_strap_i = 1'b0;
    mit_pkg::mit_req_t req_i = '0;
    logic              region_we_i = 1'b0;
    logic [7:0]        region_i = 8'h00;
    logic              rsp_valid_o;
    logic [2:0]        rsp_bytes_o;
    logic [4:0]        rsp_states_o;
    logic [31:0]       rsp_ext_value_o;
    logic [7:0]        region_o;
    int                failures = 0;
    int                checked = 0;
    int                bin_b[16] = '{2, 1, 2, 2, 3, 2, 3, 3, 3, 3, 5, 5, 5, 4, 5, 4};
    int                bin_s[16] = '{1, 2, 1, 2, 3, 3, 2, 2, 2, 3, 3, 5, 5, 6, 4, 4};
    int                src_b[16] = '{2, 2, 2, 2, 3, 3, 3, 2, 2, 2, 4, 4, 4, 3, 4, 3};
    int                src_s[16] = '{1, 3, 1, 2, 3, 4, 2, 1, 1, 2, 2, 4, 4, 5, 3, 3};
    logic              mode_q = 1'b0;
    logic              exp_v = 1'b0;
    int                exp_b;
    int                exp_s;
    logic [31:0]       exp_x;
    logic [7:0]        exp_reg = 8'h01;

    mit_timing uut (
        .sys_clk_i        (sys_clk_i),
        .reset_i          (reset_i),
        .src_mode_strap_i (src_mode_strap_i),
        .req_i            (req_i),
        .region_we_i      (region_we_i),
        .region_i         (region_i),
        .rsp_valid_o      (rsp_valid_o),
        .rsp_bytes_o      (rsp_bytes_o),
        .rsp_states_o     (rsp_states_o),
        .rsp_ext_value_o  (rsp_ext_value_o),
        .region_o         (region_o)
    );

    always #50 sys_clk_i = ~sys_clk_i;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (failures == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    function automatic int pen(input mit_pkg::mit_loc_t l);
        return (l == mit_pkg::MIT_LOC_PORT) ? 1 : (l == mit_pkg::MIT_LOC_PERIPH) ? 2 : 0;
    endfunction

    // Strap changes later on must not move the cost column
    task automatic do_reset(input logic mode);
        @(posedge sys_clk_i);
        reset_i <= 1'b1;
        src_mode_strap_i <= mode;
        region_we_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        req_i.valid <= 1'b1;
        @(negedge sys_clk_i);
        check(32'(region_o), 32'h01);
        check(32'(rsp_valid_o), 32'h0);
        mode_q = mode;
        exp_v = 1'b0;
        exp_reg = 8'h01;
    endtask

    task automatic step(input logic v, input logic we);
        mit_pkg::mit_req_t r;
        logic [7:0]        rv;
        int                f;
        f = $urandom_range(15);
        rv = 8'($urandom);
        r.valid = v;
        r.form = mit_pkg::mit_form_t'(f);
        r.loc_a = mit_pkg::mit_loc_t'($urandom_range(3));
        r.loc_b = (f == 4) ? mit_pkg::mit_loc_t'($urandom_range(3)) : mit_pkg::MIT_LOC_PLAIN;
        r.wait_n = 4'($urandom_range(15));
        r.imm = 16'($urandom);
        @(posedge sys_clk_i);
        req_i <= r;
        region_we_i <= we;
        region_i <= rv;
        src_mode_strap_i <= 1'($urandom);
        @(negedge sys_clk_i);
        check(32'(rsp_valid_o), 32'(exp_v));
        if (exp_v)
        begin
            check(32'(rsp_bytes_o), 32'(exp_b));
            check(32'(rsp_states_o), 32'(exp_s));
            check(rsp_ext_value_o, exp_x);
        end
        check(32'(region_o), 32'(exp_reg));
        // Only the marked forms pay location penalties
        exp_v = v;
        exp_b = mode_q ? src_b[f] : bin_b[f];
        exp_s = mode_q ? src_s[f] : bin_s[f];
        if (f == 0 || f == 3 || f == 4)
            exp_s += pen(r.loc_a) + pen(r.loc_b);
        if ((f == 14 || f == 15) && r.loc_a == mit_pkg::MIT_LOC_EXT)
            exp_s += int'(r.wait_n) + 2;
        exp_x = (f == 11) ? {16'h0000, r.imm} : (f == 12) ? {16'hFFFF, r.imm} : 32'h0;
        if (we)
            exp_reg = rv;
    endtask

    initial
    begin
        #2000000;
        failures++;
        report_and_stop();
    end

    initial
    begin
        void'($urandom(32'h4FA9));
        for (int m = 0; m < 2; m++)
        begin
            do_reset(m[0]);
            repeat (400) step(1'($urandom_range(7) != 0), 1'($urandom_range(3) == 0));
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
